// ### verilog/etsc_top.sv
// External event counter and time stamp capture with read-only registers
//
// Operation
// - Eight-bit binary count of detected events
// - Count and stamps ignore host writes
// - Count wraps from 255 to zero
// - Every event after the seeding cycle counts, whatever overwrite select
// - Clear control zeroes the event count
// - Power-up: active input level seeds count one
// - Hundredths stamp: two BCD digits, full byte
// - Seconds stamp: two BCD digits, bits 6:0
// - Minutes stamp: two BCD digits, bits 6:0
// - Seconds and minutes top bits read zero, not writable
// - Keep first or last; clear zeroes stamps
`timescale 1ns/1ps
`default_nettype none

module etsc_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Event detector side
  input wire logic event_input_pin,
  input wire logic event_level_select,
  input wire logic event_detected,
  // Control bits
  input wire logic event_overwrite_select,
  input wire logic event_stamp_clear,
  // Live clock values in BCD
  input wire logic [7:0] time_hundredths,
  input wire logic [7:0] time_seconds,
  input wire logic [7:0] time_minutes,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Status
  output logic [7:0] event_occurrence_count,
  output logic stamp_held
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  etsc_pkg::etsc_state_e state;
  etsc_pkg::etsc_state_e next_state;
  logic [7:0] next_count;
  logic next_stamp_held;
  logic [7:0] next_rdata;
  logic next_rd_valid;
  logic level_active;
  logic capture;
  logic [7:0] event_stamp_hundredths;
  logic [7:0] event_stamp_seconds;
  logic [7:0] event_stamp_minutes;

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  // level select picks active level
  assign level_active = event_level_select ? event_input_pin
                                           : !event_input_pin;

  // first or last event kept
  // A clear in the same cycle frees the stamps, so the event still lands
  // Events in the seeding cycle are dropped, as for the count
  assign capture = event_detected && state == etsc_pkg::ST_RUN
                 && (event_overwrite_select || !stamp_held
                     || event_stamp_clear);

  // ****************************************************************
  // Power-up sequencing and event count
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_count = event_occurrence_count;
    unique case (state)
      etsc_pkg::ST_INIT: begin
        // seed from the pin after release
        // Sampled one cycle after reset, as the async reset cannot load it
        next_count = level_active ? etsc_pkg::COUNT_ONE
                                  : etsc_pkg::RST_COUNT;
        next_state = etsc_pkg::ST_RUN;
      end
      etsc_pkg::ST_RUN: begin
        if (event_stamp_clear) begin
          next_count = etsc_pkg::RST_COUNT;
        end
        if (event_detected) begin
          // wraps to zero at the top
          // binary increment
          // An event beside a clear is kept: the count restarts at one
          next_count = event_stamp_clear ? etsc_pkg::COUNT_ONE
                                         : etsc_pkg::etsc_incr(
                                             event_occurrence_count);
        end
      end
    endcase
  end

  // Stamp held flag drives the keep-first choice
  always_comb begin
    next_stamp_held = stamp_held;
    if (event_stamp_clear) begin
      next_stamp_held = 1'b0;
    end
    if (capture) begin
      next_stamp_held = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= etsc_pkg::ST_INIT;
      event_occurrence_count <= etsc_pkg::RST_COUNT;
      stamp_held <= 1'b0;
    end else begin
      state <= next_state;
      event_occurrence_count <= next_count;
      stamp_held <= next_stamp_held;
    end
  end

  // ****************************************************************
  // Stamp storage
  // ****************************************************************
  etsc_stamp_bank u_bank (
    .clock(clock),
    .rst(rst),
    .capture(capture),
    .clear(event_stamp_clear),
    .time_hundredths(time_hundredths),
    .time_seconds(time_seconds),
    .time_minutes(time_minutes),
    .stamp_hundredths(event_stamp_hundredths),
    .stamp_seconds(event_stamp_seconds),
    .stamp_minutes(event_stamp_minutes)
  );

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // writes never reach the stores
  // The write strobe and data are accepted and dropped on purpose
  always_comb begin
    next_rd_valid = reg_rd;
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        etsc_pkg::OFF_COUNT: next_rdata = event_occurrence_count;
        etsc_pkg::OFF_HUNDREDTHS: next_rdata = event_stamp_hundredths;
        etsc_pkg::OFF_SECONDS:
          next_rdata = etsc_pkg::etsc_mask7(event_stamp_seconds);
        etsc_pkg::OFF_MINUTES:
          next_rdata = etsc_pkg::etsc_mask7(event_stamp_minutes);
        default: next_rdata = etsc_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= etsc_pkg::READ_ZERO;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rd_valid <= next_rd_valid;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_plain_event;
    event_detected && !event_stamp_clear && state == etsc_pkg::ST_RUN;
  endsequence

  sequence s_read_of(logic [7:0] addr);
    reg_rd && reg_addr == addr;
  endsequence

  sequence s_keep_first;
    event_detected && !event_overwrite_select && stamp_held
      && !event_stamp_clear && state == etsc_pkg::ST_RUN;
  endsequence

  a_count_incr: assert property (
    s_plain_event |=> event_occurrence_count
      == etsc_pkg::etsc_incr($past(event_occurrence_count)))
    else $error("event count did not step by one");

  a_count_wrap: assert property (
    s_plain_event and event_occurrence_count == 8'hff
      |=> event_occurrence_count == 8'h00)
    else $error("event count did not wrap to zero");

  a_count_indep: assert property (
    s_plain_event and stamp_held and !event_overwrite_select
      |=> event_occurrence_count != $past(event_occurrence_count)
        && $stable(event_stamp_hundredths))
    else $error("count or first stamp handled wrongly");

  a_clear_count: assert property (
    event_stamp_clear && !event_detected && state == etsc_pkg::ST_RUN
      |=> event_occurrence_count == 8'h00 && !stamp_held)
    else $error("clear did not zero the count");

  a_clear_set_wins: assert property (
    event_stamp_clear && event_detected && state == etsc_pkg::ST_RUN
      |=> event_occurrence_count == 8'h01 && stamp_held)
    else $error("event beside clear was lost");

  a_init_seed: assert property (
    state == etsc_pkg::ST_INIT |=> state == etsc_pkg::ST_RUN
      && event_occurrence_count == {7'h00, $past(level_active)})
    else $error("power-up seed wrong");

  a_write_ignored: assert property (
    reg_wr && !event_detected && !event_stamp_clear
      && state == etsc_pkg::ST_RUN
      |=> $stable(event_occurrence_count) && $stable(event_stamp_minutes))
    else $error("host write changed a stored value");

  a_seconds_top: assert property (
    s_read_of(etsc_pkg::OFF_SECONDS) or s_read_of(etsc_pkg::OFF_MINUTES)
      |=> reg_rd_valid && !reg_rdata[7])
    else $error("stamp top bit read as one");

  a_stamp_capture: assert property (
    capture |=> event_stamp_seconds
      == etsc_pkg::etsc_mask7($past(time_seconds)))
    else $error("seconds stamp not captured");

  a_last_kept: assert property (
    event_detected && event_overwrite_select && state == etsc_pkg::ST_RUN
      |=> event_stamp_minutes == etsc_pkg::etsc_mask7($past(time_minutes)))
    else $error("last event did not overwrite");

  a_count_read: assert property (
    s_read_of(etsc_pkg::OFF_COUNT)
      |=> reg_rd_valid && reg_rdata == $past(event_occurrence_count))
    else $error("count read back wrong");

  a_first_kept: assert property (
    s_keep_first |=> $stable(event_stamp_seconds)
      && $stable(event_stamp_minutes) && stamp_held)
    else $error("first stamp was overwritten");

  a_held_set: assert property (
    capture |=> stamp_held)
    else $error("stamp held flag not set");

  a_clear_stamps: assert property (
    event_stamp_clear && !event_detected && state == etsc_pkg::ST_RUN
      |=> event_stamp_seconds == 8'h00 && event_stamp_minutes == 8'h00)
    else $error("clear left a stamp behind");

  a_hund_read: assert property (
    s_read_of(etsc_pkg::OFF_HUNDREDTHS)
      |=> reg_rdata == $past(event_stamp_hundredths))
    else $error("hundredths read back wrong");

  a_secs_read: assert property (
    s_read_of(etsc_pkg::OFF_SECONDS)
      |=> reg_rdata == $past(event_stamp_seconds))
    else $error("seconds read back wrong");

  a_mins_read: assert property (
    s_read_of(etsc_pkg::OFF_MINUTES)
      |=> reg_rdata == $past(event_stamp_minutes))
    else $error("minutes read back wrong");

  a_stamp_top: assert property (
    !event_stamp_seconds[7] && !event_stamp_minutes[7])
    else $error("stored stamp top bit set");

  a_count_hold: assert property (
    !event_detected && !event_stamp_clear && state == etsc_pkg::ST_RUN
      |=> $stable(event_occurrence_count))
    else $error("count moved without an event");

  a_unmapped_read: assert property (
    reg_rd && (reg_addr < etsc_pkg::OFF_COUNT
      || reg_addr > etsc_pkg::OFF_MINUTES)
      |=> reg_rd_valid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_valid_pulse: assert property (
    !reg_rd |=> !reg_rd_valid)
    else $error("read valid without a read");

  a_rd_stand: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_stay_run: assert property (
    state == etsc_pkg::ST_RUN |=> state == etsc_pkg::ST_RUN)
    else $error("left run state without reset");

endmodule

`default_nettype wire

// ### verilog/etsc_pkg.sv
// Shared constants and types for the external event time stamp capture
package etsc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_COUNT = 8'h26;
  localparam logic [7:0] OFF_HUNDREDTHS = 8'h27;
  localparam logic [7:0] OFF_SECONDS = 8'h28;
  localparam logic [7:0] OFF_MINUTES = 8'h29;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_STAMP = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] MASK_LOW7 = 8'h7f;

  // ****************************************************************
  // Power-up sequencing
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN = 2'b10
  } etsc_state_e;

  // Bit 7 of the seconds and minutes stamps is forced low
  function automatic logic [7:0] etsc_mask7(input logic [7:0] value);
    etsc_mask7 = value & MASK_LOW7;
  endfunction

  // Next count value with wrap from the top back to zero
  function automatic logic [7:0] etsc_incr(input logic [7:0] value);
    etsc_incr = value + COUNT_ONE;
  endfunction

endpackage

// ### verilog/etsc_stamp_bank.sv
// Stamp registers for hundredths, seconds and minutes of an event
`timescale 1ns/1ps
`default_nettype none

module etsc_stamp_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic capture,
  input wire logic clear,
  // Live clock values
  input wire logic [7:0] time_hundredths,
  input wire logic [7:0] time_seconds,
  input wire logic [7:0] time_minutes,
  // Stored stamps
  output logic [7:0] stamp_hundredths,
  output logic [7:0] stamp_seconds,
  output logic [7:0] stamp_minutes
);

  logic [7:0] next_hundredths;
  logic [7:0] next_seconds;
  logic [7:0] next_minutes;

  // ****************************************************************
  // Capture and clear
  // ****************************************************************
  always_comb begin
    next_hundredths = stamp_hundredths;
    next_seconds = stamp_seconds;
    next_minutes = stamp_minutes;
    if (capture) begin
      next_hundredths = time_hundredths;
      next_seconds = etsc_pkg::etsc_mask7(time_seconds);
      next_minutes = etsc_pkg::etsc_mask7(time_minutes);
    end else if (clear) begin
      next_hundredths = etsc_pkg::RST_STAMP;
      next_seconds = etsc_pkg::RST_STAMP;
      next_minutes = etsc_pkg::RST_STAMP;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stamp_hundredths <= etsc_pkg::RST_STAMP;
      stamp_seconds <= etsc_pkg::RST_STAMP;
      stamp_minutes <= etsc_pkg::RST_STAMP;
    end else begin
      stamp_hundredths <= next_hundredths;
      stamp_seconds <= next_seconds;
      stamp_minutes <= next_minutes;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_bank_capture: assert property (
    @(posedge clock) disable iff (rst)
    capture |=> stamp_hundredths == $past(time_hundredths)
      && stamp_minutes == etsc_pkg::etsc_mask7($past(time_minutes)))
    else $error("stamp capture lost a field");

  a_bank_clear: assert property (
    @(posedge clock) disable iff (rst)
    clear && !capture |=> stamp_hundredths == 8'h00
      && stamp_seconds == 8'h00 && stamp_minutes == 8'h00)
    else $error("stamp clear did not zero");

endmodule

`default_nettype wire

// ### bench/etsc_event_source.sv
// Model of the external event source in front of the capture block
`timescale 1ns/1ps
`default_nettype none

module etsc_event_source (
  // Clock
  input wire logic clock,
  // Event side
  output logic event_input_pin,
  output logic event_detected
);
  // ****************************************************************
  // Pin level and detector strobe
  // ****************************************************************
  // Pin level is left to the bench, which sets it before each reset
  initial begin
    event_detected = 1'b0;
  end

  task automatic set_level(input logic level);
    event_input_pin = level;
  endtask

  // event strobes
  // Held high n cycles, so events arrive back to back
  task automatic pulse_n(input int n);
    @(posedge clock);
    #1 event_detected = 1'b1;
    repeat (n) @(posedge clock);
    #1 event_detected = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/external_event_timestamp_capture_bench.sv
// Self-checking bench for the event time stamp capture block
`timescale 1ns/1ps
`default_nettype none

module external_event_timestamp_capture_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic event_level_select = 1'b0;
  logic event_overwrite_select = 1'b1;
  logic event_stamp_clear = 1'b0;
  logic [7:0] time_hundredths = 8'h00;
  logic [7:0] time_seconds = 8'h00;
  logic [7:0] time_minutes = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  wire logic [7:0] reg_rdata;
  wire logic reg_rd_valid;
  wire logic [7:0] event_occurrence_count;
  wire logic stamp_held;
  wire logic event_input_pin;
  wire logic event_detected;
  logic [31:0] seed = 32'h0000_0056;
  logic [7:0] eh, es, em, cnt;
  int mismatches = 0;
  int num_checks = 0;

  always #50 clock = ~clock;

  etsc_event_source src_u (
    .clock(clock),
    .event_input_pin(event_input_pin),
    .event_detected(event_detected)
  );

  etsc_top dut_u (
    .clock(clock), .rst(rst),
    .event_input_pin(event_input_pin),
    .event_level_select(event_level_select),
    .event_detected(event_detected),
    .event_overwrite_select(event_overwrite_select),
    .event_stamp_clear(event_stamp_clear),
    .time_hundredths(time_hundredths),
    .time_seconds(time_seconds), .time_minutes(time_minutes),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .event_occurrence_count(event_occurrence_count),
    .stamp_held(stamp_held)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [7:0] rand_bcd(input int limit);
    int v;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    v = int'(seed % limit);
    rand_bcd = 8'(((v / 10) << 4) | (v % 10));
  endfunction

  // Seconds and minutes stamps read with the top bit clear
  function automatic logic [7:0] exp_low7(input logic [7:0] v);
    exp_low7 = v & 8'h7f;
  endfunction

  // Seed is one when the pin sits at the selected active level
  function automatic logic [7:0] exp_seed(input logic pin, input logic sel);
    exp_seed = (pin == sel) ? 8'h01 : 8'h00;
  endfunction

  // Answer is registered on the taking edge and checked just after it
  task automatic rd_check(input string what, input logic [7:0] addr,
                          input logic [7:0] exp);
    @(posedge clock);
    #1 reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    check("rd_valid", {7'h00, reg_rd_valid}, 8'h01);
    check(what, reg_rdata, exp);
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] d);
    @(posedge clock);
    #1 reg_addr = addr;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
  endtask

  task automatic do_reset(input logic pin, input logic sel);
    src_u.set_level(pin);
    event_level_select = sel;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Live time moves away afterwards so stamps must be held
  task automatic fire(input int n, input logic [7:0] h, s, m);
    time_hundredths = h;
    time_seconds = s;
    time_minutes = m;
    src_u.pulse_n(n);
    cnt = cnt + 8'(n);
    time_hundredths = ~h;
    time_seconds = ~s;
    time_minutes = ~m;
  endtask

  task automatic stamps_check(input logic [7:0] h, s, m);
    rd_check("hundredths", etsc_pkg::OFF_HUNDREDTHS, h);
    rd_check("seconds", etsc_pkg::OFF_SECONDS,
             exp_low7(s));
    rd_check("minutes", etsc_pkg::OFF_MINUTES,
             exp_low7(m));
    rd_check("count", etsc_pkg::OFF_COUNT, cnt);
  endtask

  task automatic clear_all();
    @(posedge clock);
    #1 event_stamp_clear = 1'b1;
    @(posedge clock);
    #1 event_stamp_clear = 1'b0;
    cnt = 8'h00;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    // power-up seed, reset once for each of the four pin and level select pairs
    for (int i = 0; i < 4; i++) begin
      do_reset(i[0], i[1]);
      cnt = exp_seed(i[0], i[1]);
      check("seed", event_occurrence_count, cnt);
    end
    stamps_check(8'h00, 8'h00, 8'h00);
    for (int k = 0; k < 20; k++) begin
      eh = (k == 0) ? 8'h99 : rand_bcd(100);
      es = (k == 0) ? 8'hd9 : rand_bcd(60) | {seed[3], 7'h00};
      em = (k == 0) ? 8'hd9 : rand_bcd(60) | {seed[4], 7'h00};
      fire(1, eh, es, em);
      stamps_check(eh, es, em);
    end
    for (int a = 8'h26; a < 8'h2a; a++) wr_reg(8'(a), 8'hff);
    stamps_check(eh, es, em);
    clear_all();
    check("held", {7'h00, stamp_held}, 8'h00);
    stamps_check(8'h00, 8'h00, 8'h00);
    event_overwrite_select = 1'b0;
    fire(1, 8'h42, 8'h17, 8'h33);
    fire(1, 8'h58, 8'h44, 8'h21);
    check("held", {7'h00, stamp_held}, 8'h01);
    stamps_check(8'h42, 8'h17, 8'h33);
    fire(253, 8'h11, 8'h22, 8'h33);
    check("top", event_occurrence_count, 8'hff);
    fire(1, 8'h11, 8'h22, 8'h33);
    check("wrap", event_occurrence_count, 8'h00);
    fire(2, 8'h11, 8'h22, 8'h33);
    stamps_check(8'h42, 8'h17, 8'h33);
    // event beside a clear is kept, even when keeping first
    time_hundredths = 8'h64;
    time_seconds = 8'h38;
    time_minutes = 8'h57;
    fork
      src_u.pulse_n(1);
      clear_all();
    join
    cnt = 8'h01;
    check("held", {7'h00, stamp_held}, 8'h01);
    stamps_check(8'h64, 8'h38, 8'h57);
    rd_check("unmapped", 8'h2a, 8'h00);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
